// ==== rtl/ilbc_regs.sv ====
// isa/lpc bus control registers with bios, recovery and shadow logic
`timescale 1ns/1ps

module ilbc_regs #(
	parameter int BCLK_HALF_CYC = ilbc_pkg::BCLK_HALF_CYC
) (
	input  wire logic       i_clk_sys,
	input  wire logic       i_rst,
	input  wire logic       i_cfg_wr,
	input  wire logic       i_cfg_rd,
	input  wire logic [7:0] i_cfg_addr,
	input  wire logic [7:0] i_cfg_wdata,
	output logic [7:0]      o_cfg_rdata,
	input  wire logic       i_bios_on_isa_select,
	input  wire logic       i_bios_wr_req,
	output logic            o_bios_wr_allow,
	output logic [1:0]      o_bios_cmd_bclks,
	output logic            o_rom_write_flag_set,
	output logic            o_bios_write_alarm_set,
	output logic            o_system_mgmt_interrupt,
	input  wire logic       i_isa_io_end,
	input  wire logic       i_lpc_io_end,
	input  wire logic       i_legacy_io_end,
	output logic            o_isa_io_hold,
	output logic            o_lpc_io_hold,
	output logic            o_legacy_io_hold,
	input  wire logic       i_rtc_nmi_disable,
	input  wire logic       i_sys_port_wr,
	input  wire logic [7:0] i_sys_port_wdata,
	output logic            o_fast_cpu_reset,
	input  wire logic       i_leg_rd,
	input  wire logic       i_leg_wr,
	input  wire logic [7:0] i_leg_addr,
	output logic            o_leg_valid,
	output logic [3:0]      o_leg_rd_src,
	output logic [3:0]      o_leg_rd_idx,
	output logic [2:0]      o_leg_wr_dst,
	output logic            o_shadow_mode
);

	// ************************************************************
	// configuration registers
	// ************************************************************
	logic       rom_write_permit_r;
	logic       rom_short_wait_r;
	logic       bios_lock_arm_r;
	logic       io_recovery_select_r;
	logic       lpc_recovery_apply_r;
	logic       shadow_read_select_r;
	logic       fast_cpu_reset_permit_r;
	logic       must_low_bit_r;
	logic       wr_one;
	logic       wr_two;
	logic       permit_rise;
	logic [7:0] ctl_one_rd;
	logic [7:0] ctl_two_rd;

	assign wr_one = i_cfg_wr && i_cfg_addr == ilbc_pkg::CTL_ONE_OFS;
	assign wr_two = i_cfg_wr && i_cfg_addr == ilbc_pkg::CTL_TWO_OFS;
	assign permit_rise = wr_one && !rom_write_permit_r
		&& i_cfg_wdata[ilbc_pkg::ROM_WRITE_PERMIT_BIT];

	always_ff @(posedge i_clk_sys or posedge i_rst) begin
		if (i_rst) begin
			rom_write_permit_r <=
				ilbc_pkg::CTL_ONE_RST[ilbc_pkg::ROM_WRITE_PERMIT_BIT];
			rom_short_wait_r <=
				ilbc_pkg::CTL_ONE_RST[ilbc_pkg::ROM_SHORT_WAIT_BIT];
			io_recovery_select_r <=
				ilbc_pkg::CTL_ONE_RST[ilbc_pkg::IO_RECOVERY_SELECT_BIT];
			lpc_recovery_apply_r <=
				ilbc_pkg::CTL_ONE_RST[ilbc_pkg::LPC_RECOVERY_APPLY_BIT];
		end else if (wr_one) begin
			rom_write_permit_r <=
				i_cfg_wdata[ilbc_pkg::ROM_WRITE_PERMIT_BIT];
			rom_short_wait_r <= i_cfg_wdata[ilbc_pkg::ROM_SHORT_WAIT_BIT];
			io_recovery_select_r <=
				i_cfg_wdata[ilbc_pkg::IO_RECOVERY_SELECT_BIT];
			lpc_recovery_apply_r <=
				i_cfg_wdata[ilbc_pkg::LPC_RECOVERY_APPLY_BIT];
		end
	end

	// lock only ever sets; the bus reset is its sole clear
	always_ff @(posedge i_clk_sys or posedge i_rst) begin
		if (i_rst) begin
			bios_lock_arm_r <=
				ilbc_pkg::CTL_ONE_RST[ilbc_pkg::BIOS_LOCK_ARM_BIT];
		end else if (wr_one && i_cfg_wdata[ilbc_pkg::BIOS_LOCK_ARM_BIT]) begin
			bios_lock_arm_r <= 1'b1;
		end
	end

	// must low bit is stored as written; software keeps it zero
	always_ff @(posedge i_clk_sys or posedge i_rst) begin
		if (i_rst) begin
			shadow_read_select_r <=
				ilbc_pkg::CTL_TWO_RST[ilbc_pkg::SHADOW_READ_SELECT_BIT];
			fast_cpu_reset_permit_r <=
				ilbc_pkg::CTL_TWO_RST[ilbc_pkg::FAST_CPU_RESET_PERMIT_BIT];
			must_low_bit_r <= ilbc_pkg::CTL_TWO_RST[ilbc_pkg::MUST_LOW_BIT];
		end else if (wr_two) begin
			shadow_read_select_r <=
				i_cfg_wdata[ilbc_pkg::SHADOW_READ_SELECT_BIT];
			fast_cpu_reset_permit_r <=
				i_cfg_wdata[ilbc_pkg::FAST_CPU_RESET_PERMIT_BIT];
			must_low_bit_r <= i_cfg_wdata[ilbc_pkg::MUST_LOW_BIT];
		end
	end

	always_comb begin
		ctl_one_rd = 8'h00;
		ctl_one_rd[ilbc_pkg::ROM_WRITE_PERMIT_BIT] = rom_write_permit_r;
		ctl_one_rd[ilbc_pkg::ROM_SHORT_WAIT_BIT] = rom_short_wait_r;
		ctl_one_rd[ilbc_pkg::BIOS_LOCK_ARM_BIT] = bios_lock_arm_r;
		ctl_one_rd[ilbc_pkg::IO_RECOVERY_SELECT_BIT] = io_recovery_select_r;
		ctl_one_rd[ilbc_pkg::LPC_RECOVERY_APPLY_BIT] = lpc_recovery_apply_r;
		ctl_two_rd = 8'h00;
		ctl_two_rd[ilbc_pkg::SHADOW_READ_SELECT_BIT] = shadow_read_select_r;
		ctl_two_rd[ilbc_pkg::NMI_MASK_MIRROR_BIT] =
			i_rtc_nmi_disable;
		ctl_two_rd[ilbc_pkg::FAST_CPU_RESET_PERMIT_BIT] =
			fast_cpu_reset_permit_r;
		ctl_two_rd[ilbc_pkg::MUST_LOW_BIT] = must_low_bit_r;
	end

	// unmapped offsets read as zero
	always_ff @(posedge i_clk_sys or posedge i_rst) begin
		if (i_rst) begin
			o_cfg_rdata <= 8'h00;
		end else if (i_cfg_rd) begin
			if (i_cfg_addr == ilbc_pkg::CTL_ONE_OFS) begin
				o_cfg_rdata <= ctl_one_rd;
			end else if (i_cfg_addr == ilbc_pkg::CTL_TWO_OFS) begin
				o_cfg_rdata <= ctl_two_rd;
			end else begin
				o_cfg_rdata <= 8'h00;
			end
		end
	end

	// ************************************************************
	// bios rom access control and events
	// ************************************************************
	always_ff @(posedge i_clk_sys or posedge i_rst) begin
		if (i_rst) begin
			o_bios_wr_allow <= 1'b0;
			o_bios_cmd_bclks <= 2'h0;
		end else begin
			o_bios_wr_allow <= i_bios_wr_req && rom_write_permit_r;
			if (!i_bios_on_isa_select) begin
				o_bios_cmd_bclks <= 2'h0;
			end else if (rom_short_wait_r) begin
				o_bios_cmd_bclks <= ilbc_pkg::BIOS_CMD_SHORT_BCLKS;
			end else begin
				o_bios_cmd_bclks <= ilbc_pkg::BIOS_CMD_LONG_BCLKS;
			end
		end
	end

	// lock is taken as it stood before the write that raises permit
	always_ff @(posedge i_clk_sys or posedge i_rst) begin
		if (i_rst) begin
			o_rom_write_flag_set <= 1'b0;
			o_bios_write_alarm_set <= 1'b0;
			o_system_mgmt_interrupt <= 1'b0;
		end else begin
			o_rom_write_flag_set <= permit_rise;
			o_bios_write_alarm_set <= permit_rise && bios_lock_arm_r;
			o_system_mgmt_interrupt <= permit_rise && bios_lock_arm_r;
		end
	end

	// ************************************************************
	// fast cpu reset through the system control port
	// ************************************************************
	always_ff @(posedge i_clk_sys or posedge i_rst) begin
		if (i_rst) begin
			o_fast_cpu_reset <= 1'b0;
		end else begin
			o_fast_cpu_reset <= i_sys_port_wr && fast_cpu_reset_permit_r
				&& i_sys_port_wdata[ilbc_pkg::SYS_PORT_RESET_BIT];
		end
	end

	// ************************************************************
	// io recovery spacing
	// ************************************************************
	logic [3:0] half_div_r;
	logic       half_tick_r;
	logic [4:0] isa_load;
	logic [7:0] lpc_load;
	logic       isa_busy;
	logic       pclk_busy;
	logic       lpc_busy;
	logic       lpc_start;

	always_ff @(posedge i_clk_sys or posedge i_rst) begin
		if (i_rst) begin
			half_div_r <= 4'h0;
			half_tick_r <= 1'b0;
		end else if (half_div_r == 4'(BCLK_HALF_CYC - 1)) begin
			half_div_r <= 4'h0;
			half_tick_r <= 1'b1;
		end else begin
			half_div_r <= half_div_r + 4'h1;
			half_tick_r <= 1'b0;
		end
	end

	assign isa_load = io_recovery_select_r ?
		5'(ilbc_pkg::ISA_REC_LONG_HALF) :
		5'(ilbc_pkg::ISA_REC_SHORT_HALF);
	assign lpc_load = io_recovery_select_r ?
		8'(ilbc_pkg::LPC_REC_LONG_CYC) :
		8'(ilbc_pkg::LPC_REC_SHORT_CYC);
	// lpc io cycles only start the spacing when the apply bit is set
	assign lpc_start = i_legacy_io_end
		|| (i_lpc_io_end && lpc_recovery_apply_r);

	ilbc_rec_timer #(.W(5)) u_isa_rec (
		.i_clk_sys (i_clk_sys),
		.i_rst     (i_rst),
		.i_tick    (half_tick_r),
		.i_start   (i_isa_io_end),
		.i_load    (isa_load),
		.o_busy    (isa_busy)
	);

	ilbc_rec_timer #(.W(8)) u_lpc_rec (
		.i_clk_sys (i_clk_sys),
		.i_rst     (i_rst),
		.i_tick    (1'b1),
		.i_start   (lpc_start),
		.i_load    (lpc_load),
		.o_busy    (pclk_busy)
	);

	assign lpc_busy = pclk_busy && lpc_recovery_apply_r;

	// holds gate io command starts only; memory cycles never see them
	always_ff @(posedge i_clk_sys or posedge i_rst) begin
		if (i_rst) begin
			o_isa_io_hold <= 1'b0;
			o_lpc_io_hold <= 1'b0;
			o_legacy_io_hold <= 1'b0;
		end else begin
			o_isa_io_hold <= isa_busy;
			o_lpc_io_hold <= lpc_busy;
			o_legacy_io_hold <= pclk_busy;
		end
	end

	// ************************************************************
	// legacy port shadow steering
	// ************************************************************
	function automatic ilbc_pkg::ilbc_port_class_t port_class(
		input logic [7:0] a
	);
		if (a[7:3] == 5'h00) begin
			port_class = a[0] ? ilbc_pkg::PC_DMA_CNT : ilbc_pkg::PC_DMA_ADDR;
		end else if (a[7:4] == 4'hc && a[0] == 1'b0) begin
			port_class = a[1] ? ilbc_pkg::PC_DMA_CNT : ilbc_pkg::PC_DMA_ADDR;
		end else if (a == 8'h08) begin
			port_class = ilbc_pkg::PC_DMA_CMD_S;
		end else if (a == 8'hd0) begin
			port_class = ilbc_pkg::PC_DMA_CMD_M;
		end else if (a >= 8'h09 && a <= 8'h0b) begin
			port_class = ilbc_pkg::PC_DMA_RSVD;
		end else if (a == 8'hd2 || a == 8'hd4 || a == 8'hd6) begin
			port_class = ilbc_pkg::PC_DMA_RSVD;
		end else if (a == 8'h0f || a == 8'hde) begin
			port_class = ilbc_pkg::PC_DMA_MASK;
		end else if (a == 8'h40) begin
			port_class = ilbc_pkg::PC_TMR0;
		end else if (a == 8'h20) begin
			port_class = ilbc_pkg::PC_IRQ1;
		end else begin
			port_class = ilbc_pkg::PC_OTHER;
		end
	endfunction

	ilbc_pkg::ilbc_port_class_t rd_cls;
	ilbc_pkg::ilbc_port_class_t wr_cls;
	logic       shadow_prev_r;
	logic       shadow_enter;
	logic       shadow_rd;
	logic [3:0] dma_s_idx;
	logic [3:0] dma_m_idx;
	logic [3:0] tmr_idx;
	logic [3:0] irq_idx;

	assign rd_cls = port_class(i_leg_addr);
	assign wr_cls = port_class(i_leg_addr);
	assign shadow_rd = i_leg_rd && shadow_read_select_r;
	assign shadow_enter = shadow_read_select_r && !shadow_prev_r;

	always_ff @(posedge i_clk_sys or posedge i_rst) begin
		if (i_rst) begin
			shadow_prev_r <= 1'b0;
			o_shadow_mode <= 1'b0;
		end else begin
			shadow_prev_r <= shadow_read_select_r;
			o_shadow_mode <= shadow_read_select_r;
		end
	end

	ilbc_seq_ptr #(.LAST(ilbc_pkg::DMA_SEQ_LAST)) u_dma_s_seq (
		.i_clk_sys (i_clk_sys),
		.i_rst     (i_rst),
		.i_restart (shadow_enter),
		.i_step    (shadow_rd && rd_cls == ilbc_pkg::PC_DMA_CMD_S),
		.o_idx     (dma_s_idx)
	);

	ilbc_seq_ptr #(.LAST(ilbc_pkg::DMA_SEQ_LAST)) u_dma_m_seq (
		.i_clk_sys (i_clk_sys),
		.i_rst     (i_rst),
		.i_restart (shadow_enter),
		.i_step    (shadow_rd && rd_cls == ilbc_pkg::PC_DMA_CMD_M),
		.o_idx     (dma_m_idx)
	);

	ilbc_seq_ptr #(.LAST(ilbc_pkg::TMR_SEQ_LAST)) u_tmr_seq (
		.i_clk_sys (i_clk_sys),
		.i_rst     (i_rst),
		.i_restart (shadow_enter),
		.i_step    (shadow_rd && rd_cls == ilbc_pkg::PC_TMR0),
		.o_idx     (tmr_idx)
	);

	ilbc_seq_ptr #(.LAST(ilbc_pkg::IRQ_SEQ_LAST)) u_irq_seq (
		.i_clk_sys (i_clk_sys),
		.i_rst     (i_rst),
		.i_restart (shadow_enter),
		.i_step    (shadow_rd && rd_cls == ilbc_pkg::PC_IRQ1),
		.o_idx     (irq_idx)
	);

	// a strobe with both rd and wr is treated as a read
	always_ff @(posedge i_clk_sys or posedge i_rst) begin
		if (i_rst) begin
			o_leg_valid <= 1'b0;
			o_leg_rd_src <= ilbc_pkg::RS_NORMAL;
			o_leg_rd_idx <= 4'h0;
			o_leg_wr_dst <= ilbc_pkg::WD_NORMAL;
		end else begin
			o_leg_valid <= i_leg_rd || i_leg_wr;
			o_leg_rd_src <= ilbc_pkg::RS_NORMAL;
			o_leg_rd_idx <= 4'h0;
			o_leg_wr_dst <= ilbc_pkg::WD_NORMAL;
			if (i_leg_rd && !shadow_read_select_r) begin
				if (rd_cls == ilbc_pkg::PC_DMA_MASK) begin
					o_leg_rd_src <= ilbc_pkg::RS_RESERVED;
				end
			end else if (i_leg_rd) begin
				unique case (rd_cls)
				ilbc_pkg::PC_DMA_ADDR:
					o_leg_rd_src <= ilbc_pkg::RS_DMA_BASE_ADDR;
				ilbc_pkg::PC_DMA_CNT:
					o_leg_rd_src <= ilbc_pkg::RS_DMA_BASE_CNT;
				ilbc_pkg::PC_DMA_CMD_S: begin
					o_leg_rd_src <= ilbc_pkg::RS_DMA_SEQ;
					o_leg_rd_idx <= dma_s_idx;
				end
				ilbc_pkg::PC_DMA_CMD_M: begin
					o_leg_rd_src <= ilbc_pkg::RS_DMA_SEQ;
					o_leg_rd_idx <= dma_m_idx;
				end
				ilbc_pkg::PC_DMA_MASK:
					o_leg_rd_src <= ilbc_pkg::RS_DMA_ALL_MASK;
				ilbc_pkg::PC_TMR0: begin
					o_leg_rd_src <= ilbc_pkg::RS_TMR_SEQ;
					o_leg_rd_idx <= tmr_idx;
				end
				ilbc_pkg::PC_IRQ1: begin
					o_leg_rd_src <= ilbc_pkg::RS_IRQ_SEQ;
					o_leg_rd_idx <= irq_idx;
				end
				default:
					o_leg_rd_src <= ilbc_pkg::RS_NORMAL;
				endcase
			end else if (i_leg_wr && shadow_read_select_r) begin
				unique case (wr_cls)
				ilbc_pkg::PC_DMA_ADDR:
					o_leg_wr_dst <= ilbc_pkg::WD_CUR_ADDR;
				ilbc_pkg::PC_DMA_CNT:
					o_leg_wr_dst <= ilbc_pkg::WD_CUR_CNT;
				ilbc_pkg::PC_DMA_CMD_S, ilbc_pkg::PC_DMA_CMD_M:
					o_leg_wr_dst <= ilbc_pkg::WD_DMA_STATUS;
				ilbc_pkg::PC_DMA_RSVD:
					o_leg_wr_dst <= ilbc_pkg::WD_IGNORE;
				default:
					o_leg_wr_dst <= ilbc_pkg::WD_NORMAL;
				endcase
			end
		end
	end

endmodule

// ==== rtl/ilbc_pkg.sv ====
// shared constants and types of the isa/lpc bus control register block
package ilbc_pkg;

	// ************************************************************
	// register map and field positions
	// ************************************************************
	localparam logic [7:0] CTL_ONE_OFS  = 8'h40;
	localparam logic [7:0] CTL_ONE_RST  = 8'h00;
	localparam logic [7:0] CTL_TWO_OFS  = 8'h41;
	localparam logic [7:0] CTL_TWO_RST  = 8'h02;
	localparam int ROM_WRITE_PERMIT_BIT      = 0;
	localparam int ROM_SHORT_WAIT_BIT        = 1;
	localparam int BIOS_LOCK_ARM_BIT         = 2;
	localparam int IO_RECOVERY_SELECT_BIT    = 3;
	localparam int LPC_RECOVERY_APPLY_BIT    = 4;
	localparam int SHADOW_READ_SELECT_BIT    = 0;
	localparam int NMI_MASK_MIRROR_BIT       = 1;
	localparam int FAST_CPU_RESET_PERMIT_BIT = 5;
	localparam int MUST_LOW_BIT              = 7;
	localparam int SYS_PORT_RESET_BIT        = 0;

	// ************************************************************
	// timing: figures in their own units, then clock counts
	// ************************************************************
	localparam int CLK_PERIOD_NS   = 10;
	localparam int PCLK_PERIOD_NS  = 30;
	localparam int BCLK_PERIOD_NS  = 120;
	localparam int BCLK_HALF_CYC   = BCLK_PERIOD_NS / 2 / CLK_PERIOD_NS;
	// isa recovery counted in half bclk periods (5.5 and 13.5 bclk)
	localparam int ISA_REC_SHORT_HALF = 11;
	localparam int ISA_REC_LONG_HALF  = 27;
	localparam int LPC_REC_SHORT_PCLK = 22;
	localparam int LPC_REC_LONG_PCLK  = 54;
	localparam int LPC_REC_SHORT_CYC  =
		(LPC_REC_SHORT_PCLK * PCLK_PERIOD_NS + CLK_PERIOD_NS - 1)
		/ CLK_PERIOD_NS;
	localparam int LPC_REC_LONG_CYC   =
		(LPC_REC_LONG_PCLK * PCLK_PERIOD_NS + CLK_PERIOD_NS - 1)
		/ CLK_PERIOD_NS;
	localparam logic [1:0] BIOS_CMD_LONG_BCLKS  = 2'h2;
	localparam logic [1:0] BIOS_CMD_SHORT_BCLKS = 2'h1;

	// ************************************************************
	// shadow read sequence lengths (last index)
	// ************************************************************
	localparam int DMA_SEQ_LAST = 5;
	localparam int TMR_SEQ_LAST = 6;
	localparam int IRQ_SEQ_LAST = 13;

	typedef enum logic [3:0] {
		PC_OTHER, PC_DMA_ADDR, PC_DMA_CNT, PC_DMA_CMD_S, PC_DMA_CMD_M,
		PC_DMA_RSVD, PC_DMA_MASK, PC_TMR0, PC_IRQ1
	} ilbc_port_class_t;

	typedef enum logic [3:0] {
		RS_NORMAL        = 4'h0,
		RS_DMA_BASE_ADDR = 4'h1,
		RS_DMA_BASE_CNT  = 4'h2,
		RS_DMA_SEQ       = 4'h3,
		RS_DMA_ALL_MASK  = 4'h4,
		RS_TMR_SEQ       = 4'h5,
		RS_IRQ_SEQ       = 4'h6,
		RS_RESERVED      = 4'h7
	} ilbc_rd_src_t;

	typedef enum logic [2:0] {
		WD_NORMAL     = 3'h0,
		WD_CUR_ADDR   = 3'h1,
		WD_CUR_CNT    = 3'h2,
		WD_DMA_STATUS = 3'h3,
		WD_IGNORE     = 3'h4
	} ilbc_wr_dst_t;

endpackage

// ==== rtl/ilbc_seq_ptr.sv ====
// read sequence pointer for one shadowed legacy port
`timescale 1ns/1ps

module ilbc_seq_ptr #(
	parameter int LAST = 5
) (
	input  wire logic       i_clk_sys,
	input  wire logic       i_rst,
	input  wire logic       i_restart,
	input  wire logic       i_step,
	output logic [3:0]      o_idx
);

	logic [3:0] idx_r;

	// restart beats a step in the same cycle
	always_ff @(posedge i_clk_sys or posedge i_rst) begin
		if (i_rst) begin
			idx_r <= 4'h0;
		end else if (i_restart) begin
			idx_r <= 4'h0;
		end else if (i_step) begin
			if (idx_r == 4'(LAST)) begin
				idx_r <= 4'h0;
			end else begin
				idx_r <= idx_r + 4'h1;
			end
		end
	end

	assign o_idx = idx_r;

endmodule

// ==== rtl/ilbc_rec_timer.sv ====
// io recovery spacing timer, counts enable ticks after a cycle ends
`timescale 1ns/1ps

module ilbc_rec_timer #(
	parameter int W = 8
) (
	input  wire logic         i_clk_sys,
	input  wire logic         i_rst,
	input  wire logic         i_tick,
	input  wire logic         i_start,
	input  wire logic [W-1:0] i_load,
	output logic              o_busy
);

	logic [W-1:0] cnt_r;

	always_ff @(posedge i_clk_sys or posedge i_rst) begin
		if (i_rst) begin
			cnt_r <= '0;
		end else if (i_start) begin
			cnt_r <= i_load;
		end else if (i_tick && cnt_r != '0) begin
			cnt_r <= cnt_r - W'(1);
		end
	end

	// busy holds while any of the spacing is left
	always_ff @(posedge i_clk_sys or posedge i_rst) begin
		if (i_rst) begin
			o_busy <= 1'b0;
		end else begin
			o_busy <= i_start || (cnt_r > W'(1))
				|| (cnt_r == W'(1) && !i_tick);
		end
	end

endmodule

// ==== verification/ilbc_regs_props.sv ====
// port-level checks of the isa/lpc bus control register block
`timescale 1ns/1ps

module ilbc_regs_props #(
	parameter int BCLK_HALF_CYC = 6
) (
	input wire logic       i_clk_sys,
	input wire logic       i_rst,
	input wire logic       i_cfg_wr,
	input wire logic [7:0] i_cfg_addr,
	input wire logic [7:0] i_cfg_wdata,
	input wire logic       i_bios_on_isa_select,
	input wire logic       i_bios_wr_req,
	input wire logic       o_bios_wr_allow,
	input wire logic [1:0] o_bios_cmd_bclks,
	input wire logic       o_rom_write_flag_set,
	input wire logic       o_bios_write_alarm_set,
	input wire logic       o_system_mgmt_interrupt,
	input wire logic       i_isa_io_end,
	input wire logic       i_legacy_io_end,
	input wire logic       o_isa_io_hold,
	input wire logic       o_legacy_io_hold,
	input wire logic       i_sys_port_wr,
	input wire logic [7:0] i_sys_port_wdata,
	input wire logic       o_fast_cpu_reset,
	input wire logic       i_leg_rd,
	input wire logic       i_leg_wr,
	input wire logic       o_leg_valid,
	input wire logic [3:0] o_leg_rd_src,
	input wire logic [3:0] o_leg_rd_idx,
	input wire logic [2:0] o_leg_wr_dst
);
	default clocking cb @(posedge i_clk_sys);
	endclocking
	default disable iff (i_rst);
	sequence s_permit_wr;
		i_cfg_wr && i_cfg_addr == ilbc_pkg::CTL_ONE_OFS && i_cfg_wdata[0];
	endsequence
	sequence s_hold_min;
		o_isa_io_hold [*8];
	endsequence
	a_bios_allow_cause: assert property (o_bios_wr_allow |-> $past(i_bios_wr_req)) else $error("allow without request");
	a_flag_cause: assert property (o_rom_write_flag_set |-> $past(i_cfg_wr && i_cfg_addr == ilbc_pkg::CTL_ONE_OFS && i_cfg_wdata[0])) else $error("flag without permit write");
	a_flag_once: assert property (s_permit_wr ##1 s_permit_wr |=> !o_rom_write_flag_set) else $error("flag on repeated permit");
	a_cmd_on_lpc: assert property (!i_bios_on_isa_select ##1 !i_bios_on_isa_select |-> o_bios_cmd_bclks == 2'h0) else $error("cmd width on lpc");
	a_cmd_on_isa: assert property (i_bios_on_isa_select ##1 i_bios_on_isa_select |-> o_bios_cmd_bclks inside {2'h1, 2'h2}) else $error("cmd width on isa");
	a_alarm_irq_pair: assert property (o_bios_write_alarm_set == o_system_mgmt_interrupt) else $error("alarm and interrupt differ");
	a_alarm_needs_flag: assert property (o_bios_write_alarm_set |-> o_rom_write_flag_set) else $error("alarm without flag");
	a_isa_hold_start: assert property (i_isa_io_end |-> ##2 o_isa_io_hold) else $error("isa hold late");
	a_isa_hold_min: assert property ($rose(o_isa_io_hold) |-> s_hold_min) else $error("isa hold short");
	a_legacy_hold: assert property (i_legacy_io_end |-> ##2 o_legacy_io_hold) else $error("legacy hold late");
	a_fast_reset: assert property (o_fast_cpu_reset |-> $past(i_sys_port_wr && i_sys_port_wdata[0])) else $error("fast reset uncaused");
	a_leg_answer: assert property (o_leg_valid == $past(i_leg_rd || i_leg_wr)) else $error("legacy answer timing");
	a_leg_idle: assert property (!o_leg_valid |-> o_leg_rd_src == 4'h0 && o_leg_rd_idx == 4'h0 && o_leg_wr_dst == 3'h0) else $error("codes outside valid");
endmodule

bind ilbc_regs ilbc_regs_props #(.BCLK_HALF_CYC(BCLK_HALF_CYC)) ilbc_regs_props_inst (.*);

// ==== verification/ilbc_io_peer.sv ====
// io target model: ends one io cycle on request, then times the hold
`timescale 1ns/1ps

module ilbc_io_peer (
	input  wire logic i_clk_sys,
	input  wire logic i_go,
	input  wire logic i_hold,
	output logic      o_end,
	output logic      o_busy,
	output int        o_gap
);
	initial begin
		o_end = 1'b0;
		o_busy = 1'b0;
		o_gap = 0;
	end
	always begin
		@(posedge i_clk_sys);
		if (i_go) begin
			#1;
			o_busy = 1'b1;
			o_end = 1'b1;
			o_gap = 0;
			@(posedge i_clk_sys) #1;
			o_end = 1'b0;
			// hold is read after the edge that updates it
			@(posedge i_clk_sys) #1;
			// no new command while hold stands
			while (i_hold) begin
				o_gap = o_gap + 1;
				@(posedge i_clk_sys) #1;
			end
			o_busy = 1'b0;
		end
	end
endmodule

// ==== verification/tb_top.sv ====
// self-checking bench for the isa/lpc bus control registers
`timescale 1ns/1ps

module tb_top;
	localparam int HC = 2;
	localparam logic [7:0] R1 = ilbc_pkg::CTL_ONE_OFS;
	localparam logic [7:0] R2 = ilbc_pkg::CTL_TWO_OFS;
	logic       i_clk_sys = 1'b0;
	logic       i_rst = 1'b1;
	logic       cw = 1'b0, cr = 1'b0, isa = 1'b0, breq = 1'b0, nmi = 1'b1;
	logic       ge = 1'b0, gl = 1'b0, lend = 1'b0, spw = 1'b0;
	logic       lr = 1'b0, lw = 1'b0, shm;
	logic [7:0] ca = 8'h00, cd = 8'h00, sd = 8'h00, la = 8'h00, rd, ev;
	logic       allow, flag, alarm, sirq, ie, le, ih, lh, gh, fr, lv, ib, lb;
	logic [1:0] cmd;
	logic [3:0] src, idx;
	logic [2:0] dst;
	int         ig, lg, k, failures = 0, samples_checked = 0;
	always #5 i_clk_sys = ~i_clk_sys;
	ilbc_regs #(.BCLK_HALF_CYC(HC)) ilbc_regs_inst (
		.i_clk_sys(i_clk_sys), .i_rst(i_rst), .i_cfg_wr(cw), .i_cfg_rd(cr),
		.i_cfg_addr(ca), .i_cfg_wdata(cd), .o_cfg_rdata(rd),
		.i_bios_on_isa_select(isa), .i_bios_wr_req(breq),
		.o_bios_wr_allow(allow), .o_bios_cmd_bclks(cmd),
		.o_rom_write_flag_set(flag), .o_bios_write_alarm_set(alarm),
		.o_system_mgmt_interrupt(sirq), .i_isa_io_end(ie),
		.i_lpc_io_end(le), .i_legacy_io_end(lend), .o_isa_io_hold(ih),
		.o_lpc_io_hold(lh), .o_legacy_io_hold(gh),
		.i_rtc_nmi_disable(nmi), .i_sys_port_wr(spw),
		.i_sys_port_wdata(sd), .o_fast_cpu_reset(fr), .i_leg_rd(lr),
		.i_leg_wr(lw), .i_leg_addr(la), .o_leg_valid(lv),
		.o_leg_rd_src(src), .o_leg_rd_idx(idx), .o_leg_wr_dst(dst),
		.o_shadow_mode(shm));
	ilbc_io_peer ilbc_io_peer_inst (.i_clk_sys(i_clk_sys), .i_go(ge),
		.i_hold(ih), .o_end(ie), .o_busy(ib), .o_gap(ig));
	ilbc_io_peer ilbc_io_peer_inst_lpc (.i_clk_sys(i_clk_sys), .i_go(gl),
		.i_hold(lh), .o_end(le), .o_busy(lb), .o_gap(lg));

	// ************************************************************
	// access and compare tasks
	// ************************************************************
	task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] s);
		samples_checked++;
		if (s !== e) begin
			failures++;
			$display("Error %s expected %h seen %h", nm, e, s);
		end
	endtask
	task automatic cfg(input logic w, input logic [7:0] a, input logic [7:0] d);
		@(posedge i_clk_sys) #1;
		cw = w;
		cr = !w;
		ca = a;
		cd = d;
		@(posedge i_clk_sys) #1;
		cw = 1'b0;
		cr = 1'b0;
		ev = {5'h00, flag, alarm, sirq};
	endtask
	task automatic bios(input logic e);
		@(posedge i_clk_sys) #1;
		breq = 1'b1;
		@(posedge i_clk_sys) #1;
		breq = 1'b0;
		chk("bios_allow", {7'h00, e}, {7'h00, allow});
	endtask
	task automatic sys(input logic [7:0] d, input logic e);
		@(posedge i_clk_sys) #1;
		spw = 1'b1;
		sd = d;
		@(posedge i_clk_sys) #1;
		spw = 1'b0;
		chk("fast_reset", {7'h00, e}, {7'h00, fr});
	endtask
	task automatic leg(input logic r, input logic [7:0] a, input logic [3:0] e, input logic [3:0] x);
		@(posedge i_clk_sys) #1;
		lr = r;
		lw = !r;
		la = a;
		@(posedge i_clk_sys) #1;
		lr = 1'b0;
		lw = 1'b0;
		chk("leg_valid", 8'h01, {7'h00, lv});
		chk("leg_src", r ? {4'h0, e} : 8'h00, {4'h0, src});
		chk("leg_idx", r ? {4'h0, x} : 8'h00, {4'h0, idx});
		chk("leg_dst", r ? 8'h00 : {4'h0, e}, {5'h00, dst});
	endtask
	task automatic gap(input logic p, input int lo);
		int g;
		@(posedge i_clk_sys) #1;
		ge = !p;
		gl = p;
		@(posedge i_clk_sys) #1;
		ge = 1'b0;
		gl = 1'b0;
		// let the peer raise busy before polling it
		@(posedge i_clk_sys) #1;
		for (k = 0; k < 400 && (ib || lb); k++) @(posedge i_clk_sys) #1;
		g = p ? lg : ig;
		chk("io_gap", 8'h01, {7'h00, k < 400 && g + 2 >= lo && g <= lo + 2});
	endtask
	task automatic give_verdict();
		$display("checked %0d failed %0d", samples_checked, failures);
		if (failures == 0 && samples_checked > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask

	task automatic t_regs();
		cfg(0, R1, 8'h00);
		chk("ctl_one", 8'h00, rd);
		cfg(0, R2, 8'h00);
		chk("ctl_two", 8'h02, rd);
		cfg(1, 8'h42, 8'hff);
		cfg(0, 8'h42, 8'h00);
		chk("unmapped", 8'h00, rd);
	endtask
	task automatic t_bios();
		isa = 1'b1;
		bios(1'b0);
		cfg(1, R1, 8'h01);
		chk("events", 8'h04, ev);
		cfg(1, R1, 8'h01);
		chk("events", 8'h00, ev);
		bios(1'b1);
		chk("cmd_bclks", 8'h02, {6'h00, cmd});
		cfg(1, R1, 8'h03);
		// the width follows the wait bit one edge later
		@(posedge i_clk_sys) #1;
		chk("cmd_bclks", 8'h01, {6'h00, cmd});
		isa = 1'b0;
		cfg(0, R1, 8'h00);
		chk("cmd_bclks", 8'h00, {6'h00, cmd});
		cfg(1, R1, 8'h00);
		bios(1'b0);
		// two permit writes back to back: only the first is a rise
		@(posedge i_clk_sys) #1;
		cw = 1'b1;
		ca = R1;
		cd = 8'h01;
		repeat (2) @(posedge i_clk_sys) #1;
		cw = 1'b0;
		chk("flag_once", 8'h00, {7'h00, flag});
	endtask
	task automatic t_lock();
		cfg(1, R1, 8'h04);
		cfg(1, R1, 8'h05);
		chk("events", 8'h07, ev);
		cfg(1, R1, 8'h00);
		cfg(0, R1, 8'h00);
		chk("ctl_one", 8'h04, rd);
	endtask
	task automatic t_recovery();
		gap(0, ilbc_pkg::ISA_REC_SHORT_HALF * HC);
		gap(1, 0);
		cfg(1, R1, 8'h10);
		gap(1, ilbc_pkg::LPC_REC_SHORT_CYC);
		cfg(1, R1, 8'h19);
		gap(0, ilbc_pkg::ISA_REC_LONG_HALF * HC);
		gap(1, ilbc_pkg::LPC_REC_LONG_CYC);
		@(posedge i_clk_sys) #1;
		lend = 1'b1;
		@(posedge i_clk_sys) #1;
		lend = 1'b0;
		@(posedge i_clk_sys) #1;
		chk("legacy_hold", 8'h01, {7'h00, gh});
		bios(1'b1);
	endtask
	task automatic t_sysport();
		cfg(1, R2, 8'h20);
		sys(8'h01, 1'b1);
		sys(8'h00, 1'b0);
		cfg(0, R2, 8'h00);
		chk("ctl_two", 8'h22, rd);
		nmi = 1'b0;
		cfg(1, R2, 8'h00);
		sys(8'h01, 1'b0);
		cfg(0, R2, 8'h00);
		chk("ctl_two", 8'h00, rd);
	endtask
	task automatic t_shadow();
		leg(1, 8'h00, 4'h0, 4'h0);
		leg(1, 8'h0f, 4'h7, 4'h0);
		cfg(1, R2, 8'h01);
		leg(1, 8'hc0, 4'h1, 4'h0);
		chk("shadow_mode", 8'h01, {7'h00, shm});
		leg(0, 8'h00, 4'h1, 4'h0);
		leg(1, 8'h01, 4'h2, 4'h0);
		leg(0, 8'hc2, 4'h2, 4'h0);
		leg(0, 8'h08, 4'h3, 4'h0);
		leg(0, 8'h0f, 4'h0, 4'h0);
		leg(1, 8'h0f, 4'h4, 4'h0);
		for (k = 0; k < 7; k++) leg(1, 8'hd0, 4'h3, 4'(k % 6));
		for (k = 0; k < 8; k++) leg(1, 8'h40, 4'h5, 4'(k % 7));
		for (k = 0; k < 15; k++) leg(1, 8'h20, 4'h6, 4'(k % 14));
		leg(1, 8'h21, 4'h0, 4'h0);
		leg(1, 8'ha1, 4'h0, 4'h0);
		leg(1, 8'h41, 4'h0, 4'h0);
		cfg(1, R2, 8'h00);
		leg(1, 8'h20, 4'h0, 4'h0);
		chk("shadow_mode", 8'h00, {7'h00, shm});
		cfg(1, R2, 8'h01);
		leg(1, 8'h40, 4'h5, 4'h0);
	endtask

	initial begin
		#200us;
		failures++;
		give_verdict();
	end
	initial begin
		repeat (20) @(posedge i_clk_sys);
		#1;
		i_rst = 1'b0;
		t_regs();
		t_bios();
		t_lock();
		t_recovery();
		t_sysport();
		t_shadow();
		give_verdict();
	end
endmodule
